// ### gate_pkg.sv
// Purpose: shared constants for the drive command gate
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes:   offsets are byte addresses of aligned words
`default_nettype none
package gate_pkg;
  // ************************************************
  // register offsets
  // ************************************************
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_CMD    = 8'h04;
  localparam logic [7:0] ADR_ALARM  = 8'h08;
  localparam logic [7:0] ADR_REFOFS = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_IRQST  = 8'h14;
  localparam logic [7:0] ADR_IRQEN  = 8'h18;
  localparam logic [7:0] ADR_IRQCLR = 8'h1C;
  // ************************************************
  // control fields and reset values
  // ************************************************
  localparam int CTL_LOCK  = 0;
  localparam int CTL_EXT   = 1;
  localparam int CTL_RSEL  = 2;
  localparam int CTL_RUN   = 3;
  localparam int CTL_SPEED = 8;
  localparam logic       LOCK_RST  = 1'b0;
  localparam logic       EXT_RST   = 1'b0;
  localparam logic       RSEL_RST  = 1'b0;
  localparam logic       RUN_RST   = 1'b1;
  localparam logic [3:0] SPEED_RST = 4'h0;
  // ************************************************
  // command bits
  // ************************************************
  localparam int CMD_REINIT = 0;
  localparam int CMD_NULL   = 1;
  localparam int CMD_CAL    = 2;
  localparam int CMD_ARST   = 3;
  localparam int CMD_MDEF   = 4;
  localparam int CMD_FDEF   = 5;
  localparam int CMD_PSAVE  = 6;
  localparam int CMD_SAVE   = 7;
  // ************************************************
  // alarm codes, limits, events
  // ************************************************
  localparam logic [7:0]  ALM_CSUM_A    = 8'h0A;
  localparam logic [7:0]  ALM_CSUM_B    = 8'h0B;
  localparam logic [15:0] OFS_LIMIT_MV  = 16'h00C8;
  localparam int EV_DONE    = 0;
  localparam int EV_REFUSED = 1;
  localparam int EV_RETRY   = 2;
  localparam int EV_ALARM   = 3;
  localparam int N_EV       = 4;
  typedef enum logic [1:0] {SV_IDLE, SV_WAIT} save_state_t;
endpackage
`default_nettype wire

// ### pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_i
// Notes:   output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] in_i,
  output var  logic [W-1:0] out_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // shift chain, first stage read only by the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= in_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // take each bit once the late stages agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_o <= '0;
    else
      for (int i = 0; i < W; i++)
        if (s2_reg[i] == s3_reg[i])
          out_o[i] <= s3_reg[i];
  end
endmodule // pin_sync
`default_nettype wire

// ### irq_ctrl.sv
// Purpose: sticky event status, enable mask, level interrupt
// Assumes: clear and enable writes are one-cycle strobes
// Notes:   an event in the clear cycle stays set
`timescale 1ns/100ps
`default_nettype none
module irq_ctrl #(
  parameter int N = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] ev_i,
  input  wire logic         en_we_i,
  input  wire logic         clr_we_i,
  input  wire logic [N-1:0] wdata_i,
  output var  logic [N-1:0] status_o,
  output var  logic [N-1:0] enable_o,
  output var  logic         irq_o
);
  logic [N-1:0] status_next;

  // set wins over clear
  always_comb
  begin
    status_next = status_o;
    if (clr_we_i)
      status_next = status_next & ~wdata_i;
    status_next = status_next | ev_i;
  end

  // status, mask and registered interrupt line
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_o <= '0;
      enable_o <= '0;
      irq_o    <= 1'b0;
    end
    else
    begin
      status_o <= status_next;
      if (en_we_i)
        enable_o <= wdata_i;
      irq_o <= |(status_next & (en_we_i ? wdata_i : enable_o));
    end
  end
endmodule // irq_ctrl
`default_nettype wire

// ### drive_parameter_command_gate.sv
// Purpose: gates command bits written to a servo drive
// Assumes: one clock, synchronous active-high reset
// Notes:   command writes are one-shot; accepted reinit, defaults and saves pulse out
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - every command needs the security lock clear
// - reinit and nulling need extended menu
// - reinit restarts serial line at stored speed
// - serial line always initialised after reset
// - nulling cancels offset only below 200 mV
// - calibration request only while drive disabled
// - calibration runs at next drive start-up
// - alarm reset clears codes, persisting alarm redisplayed
// - alarm reset refused on checksum codes 10, 11
// - mode defaults only with reserved reference off
// - full defaults: parameters, mode values, program
// - full defaults zero checksum alarm codes
// - full defaults only while program stopped
// - program save shows retry on failure
// - parameter save refused on checksum error
// - security lock blocks parameter modification
// - logic program runs while run flag set
module drive_parameter_command_gate
  import gate_pkg::*;
#(
  parameter int SPW = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        drive_enabled_i,
  input  wire logic        alarm_active_i,
  input  wire logic [15:0] offset_mv_i,
  input  wire logic        alarm_set_i,
  input  wire logic [7:0]  alarm_code_i,
  input  wire logic        save_done_i,
  input  wire logic        save_fail_i,
  output var  logic        serial_init_o,
  output var  logic [SPW-1:0] serial_speed_o,
  output var  logic        cal_run_o,
  output var  logic        mode_defaults_o,
  output var  logic        full_defaults_o,
  output var  logic        default_program_o,
  output var  logic        program_save_o,
  output var  logic        param_save_o,
  output var  logic        display_retry_o,
  output var  logic        display_alarm_o,
  output var  logic        program_run_o,
  output var  logic [15:0] ref_offset_o,
  output var  logic        irq_o
);
  // refuse speed widths that do not fit the control word field
  if (SPW < 1 || SPW > 8)
  begin : g_bad_spw
    $error("SPW must be 1 to 8");
  end

  // ************************************************
  // declarations
  // ************************************************
  logic        lock_reg;
  logic        ext_reg;
  logic        rsel_reg;
  logic [7:0]  prim_reg;
  logic [7:0]  sec_reg;
  logic        boot_done_reg;
  logic        cal_pend_reg;
  logic        drv_prev_reg;
  logic        persist_reg;
  save_state_t save_reg;
  logic [1:0]  drv_alm_s;
  logic        drv_en_s;
  logic        drv_rise;
  logic        req;
  logic        wr;
  logic [31:0] wmask;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_wd;
  logic        cmd_wr;
  logic [7:0]  cmd;
  logic [7:0]  ok;
  logic        unlocked;
  logic        csum;
  logic [15:0] mag;
  logic [N_EV-1:0] ev;
  logic [N_EV-1:0] irq_st;
  logic [N_EV-1:0] irq_en;
  logic [31:0] rdata;

  // ************************************************
  // pins and bus decode
  // ************************************************
  pin_sync #(.W(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .in_i  ({alarm_active_i, drive_enabled_i}),
    .out_o (drv_alm_s)
  );
  assign drv_en_s = drv_alm_s[0];
  assign drv_rise = drv_en_s & ~drv_prev_reg;

  // writes take effect on the edge that sees ack high
  assign req   = wb_cyc_i & wb_stb_i;
  assign wr    = req & wb_we_i & wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign ctrl_wd = (ctrl_word & ~wmask) | (wb_dat_i & wmask);
  assign cmd_wr = wr & (wb_adr_i == ADR_CMD) & wb_sel_i[0];
  assign cmd    = cmd_wr ? wb_dat_i[7:0] : 8'h00;

  // ************************************************
  // command gating
  // ************************************************
  // lock gate
  assign unlocked = ~lock_reg;
  assign csum = (prim_reg == ALM_CSUM_A) | (prim_reg == ALM_CSUM_B)
              | (sec_reg == ALM_CSUM_A) | (sec_reg == ALM_CSUM_B);
  assign mag  = offset_mv_i[15] ? 16'(-offset_mv_i) : offset_mv_i;

  // acceptance of each command bit
  always_comb
  begin
    ok = 8'h00;
    if (unlocked)
    begin
      ok[CMD_REINIT] = cmd[CMD_REINIT] & ext_reg;
      ok[CMD_NULL]  = cmd[CMD_NULL] & ext_reg & (mag < OFS_LIMIT_MV);
      ok[CMD_CAL]   = cmd[CMD_CAL] & ~drv_en_s;
      ok[CMD_ARST]  = cmd[CMD_ARST] & ~csum;
      ok[CMD_MDEF]  = cmd[CMD_MDEF] & ~rsel_reg;
      ok[CMD_FDEF]  = cmd[CMD_FDEF] & ~program_run_o;
      ok[CMD_PSAVE] = cmd[CMD_PSAVE] & (save_reg == SV_IDLE);
      ok[CMD_SAVE]  = cmd[CMD_SAVE] & ~csum & ~cmd[CMD_PSAVE]
                    & (save_reg == SV_IDLE);
    end
  end

  // refused bits only raise an event
  assign ev[EV_REFUSED] = |(cmd & ~ok);
  assign ev[EV_DONE]    = (save_reg == SV_WAIT) & save_done_i;
  assign ev[EV_RETRY]   = (save_reg == SV_WAIT) & save_fail_i;
  assign ev[EV_ALARM]   = alarm_set_i;

  // ************************************************
  // control register
  // ************************************************
  assign ctrl_word = {16'h0000, 8'(serial_speed_o), 4'h0,
                      program_run_o, rsel_reg, ext_reg, lock_reg};

  // software fields and default loading
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lock_reg       <= LOCK_RST;
      ext_reg        <= EXT_RST;
      rsel_reg       <= RSEL_RST;
      program_run_o  <= RUN_RST;
      serial_speed_o <= SPW'(SPEED_RST);
    end
    else if (ok[CMD_FDEF])
    begin
      ext_reg        <= EXT_RST;
      rsel_reg       <= RSEL_RST;
      program_run_o  <= RUN_RST;
      serial_speed_o <= SPW'(SPEED_RST);
    end
    else if (wr && wb_adr_i == ADR_CTRL)
    begin
      lock_reg <= ctrl_wd[CTL_LOCK];
      if (unlocked)
      begin
        ext_reg        <= ctrl_wd[CTL_EXT];
        rsel_reg       <= ctrl_wd[CTL_RSEL];
        program_run_o  <= ctrl_wd[CTL_RUN];
        serial_speed_o <= ctrl_wd[CTL_SPEED +: SPW];
      end
    end
  end

  // reference offset parameter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ref_offset_o <= 16'h0000;
    else if (ok[CMD_FDEF])
      ref_offset_o <= 16'h0000;
    else if (ok[CMD_NULL])
      ref_offset_o <= 16'(-offset_mv_i);
    else if (wr && wb_adr_i == ADR_REFOFS && unlocked)
      ref_offset_o <= ctrl_wd[15:0] & 16'hFFFF;
  end

  // ************************************************
  // alarm codes and display
  // ************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prim_reg <= 8'h00;
      sec_reg  <= 8'h00;
    end
    else if (alarm_set_i)
    begin
      prim_reg <= alarm_code_i; // new alarm wins over clear
      sec_reg  <= prim_reg;
    end
    else if (ok[CMD_ARST] || (ok[CMD_FDEF] && csum))
    begin
      prim_reg <= 8'h00;
      sec_reg  <= 8'h00;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      persist_reg     <= 1'b0;
      display_alarm_o <= 1'b0;
    end
    else
    begin
      if (ok[CMD_ARST])
        persist_reg <= drv_alm_s[1];
      else if (!drv_alm_s[1])
        persist_reg <= 1'b0;
      display_alarm_o <= (prim_reg != 8'h00) | persist_reg;
    end
  end

  // ************************************************
  // serial line and calibration
  // ************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      boot_done_reg <= 1'b0;
      serial_init_o <= 1'b0;
    end
    else
    begin
      boot_done_reg <= 1'b1;
      serial_init_o <= ~boot_done_reg | ok[CMD_REINIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cal_pend_reg <= 1'b0;
      cal_run_o    <= 1'b0;
      drv_prev_reg <= 1'b0;
    end
    else
    begin
      drv_prev_reg <= drv_en_s;
      cal_run_o    <= drv_rise & cal_pend_reg;
      if (ok[CMD_CAL])
        cal_pend_reg <= 1'b1;
      else if (drv_rise)
        cal_pend_reg <= 1'b0;
    end
  end

  // ************************************************
  // defaults and save handshake
  // ************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_defaults_o   <= 1'b0;
      full_defaults_o   <= 1'b0;
      default_program_o <= 1'b0;
      program_save_o    <= 1'b0;
      param_save_o      <= 1'b0;
    end
    else
    begin
      mode_defaults_o   <= ok[CMD_MDEF];
      full_defaults_o   <= ok[CMD_FDEF];
      default_program_o <= ok[CMD_FDEF];
      program_save_o    <= ok[CMD_PSAVE];
      param_save_o      <= ok[CMD_SAVE];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      save_reg        <= SV_IDLE;
      display_retry_o <= 1'b0;
    end
    else
    begin
      case (save_reg)
        SV_IDLE:
          if (ok[CMD_PSAVE] || ok[CMD_SAVE])
          begin
            save_reg        <= SV_WAIT;
            display_retry_o <= 1'b0;
          end
        SV_WAIT:
          if (save_fail_i)
          begin
            save_reg        <= SV_IDLE;
            display_retry_o <= 1'b1;
          end
          else if (save_done_i)
            save_reg <= SV_IDLE;
        default:
          save_reg <= SV_IDLE;
      endcase
    end
  end

  // ************************************************
  // interrupts and bus answer
  // ************************************************
  irq_ctrl #(.N(N_EV)) u_irq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ev_i     (ev),
    .en_we_i  (wr && wb_adr_i == ADR_IRQEN),
    .clr_we_i (wr && wb_adr_i == ADR_IRQCLR),
    .wdata_i  (wb_dat_i[N_EV-1:0]),
    .status_o (irq_st),
    .enable_o (irq_en),
    .irq_o    (irq_o)
  );

  // read mux, unmapped reads as zero
  always_comb
  begin
    case (wb_adr_i)
      ADR_CTRL:   rdata = ctrl_word;
      ADR_ALARM:  rdata = {16'h0000, sec_reg, prim_reg};
      ADR_REFOFS: rdata = {16'h0000, ref_offset_o};
      ADR_STATUS: rdata = {26'h0000000, save_reg == SV_WAIT,
                           display_retry_o, cal_pend_reg, drv_en_s,
                           csum, display_alarm_o};
      ADR_IRQST:  rdata = {28'h0000000, irq_st};
      ADR_IRQEN:  rdata = {28'h0000000, irq_en};
      default:    rdata = 32'h00000000;
    endcase
  end

  // one ack per request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rdata;
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_save_go;
    (save_reg == SV_IDLE) && (ok[CMD_PSAVE] || ok[CMD_SAVE]);
  endsequence
  sequence s_save_fail;
    (save_reg == SV_WAIT) && save_fail_i;
  endsequence

  a_lock_blocks: assert property (
    cmd_wr && lock_reg && !drv_rise |=> !mode_defaults_o && !full_defaults_o
      && !program_save_o && !param_save_o && $stable(cal_pend_reg))
    else $error("command passed while locked");
  a_ext_gate: assert property (
    cmd[CMD_REINIT] && !ext_reg && boot_done_reg |=> !serial_init_o)
    else $error("reinit without extended menu");
  a_reinit_go: assert property (
    ok[CMD_REINIT] |=> serial_init_o)
    else $error("reinit not issued");
  a_boot_init: assert property (
    $fell(rst_i) |=> serial_init_o ##1 !serial_init_o)
    else $error("no start-up serial init");
  a_null_range: assert property (
    cmd[CMD_NULL] && mag >= OFS_LIMIT_MV && !ok[CMD_FDEF]
      |=> $stable(ref_offset_o))
    else $error("offset nulled out of range");
  a_cal_refuse: assert property (
    cmd[CMD_CAL] && drv_en_s && !cal_pend_reg |=> !cal_pend_reg)
    else $error("calibration taken while enabled");
  a_cal_defer: assert property (
    cal_pend_reg && drv_rise |=> cal_run_o && !cal_pend_reg)
    else $error("calibration not run at start");
  a_arst_clear: assert property (
    ok[CMD_ARST] && !alarm_set_i |=> prim_reg == 8'h00 && sec_reg == 8'h00)
    else $error("alarm codes not cleared");
  a_arst_csum: assert property (
    cmd[CMD_ARST] && csum && !alarm_set_i && !ok[CMD_FDEF]
      |=> $stable(prim_reg) && $stable(sec_reg))
    else $error("reset taken on checksum");
  a_mdef_gate: assert property (
    cmd[CMD_MDEF] && rsel_reg |=> !mode_defaults_o)
    else $error("mode defaults with reserved ref");
  a_fdef_run: assert property (
    cmd[CMD_FDEF] && program_run_o |=> !full_defaults_o)
    else $error("full defaults while running");
  a_save_busy: assert property (
    s_save_go |=> save_reg == SV_WAIT && !display_retry_o)
    else $error("save not started");
  a_save_retry: assert property (
    s_save_fail |=> display_retry_o && save_reg == SV_IDLE)
    else $error("retry not shown");
  a_save_csum: assert property (
    cmd[CMD_SAVE] && csum |=> !param_save_o)
    else $error("save taken on checksum");
endmodule // drive_parameter_command_gate
`default_nettype wire

// ### store_model.sv
// Purpose: store medium answering program and parameter saves
// Assumes: one save request pulse at a time
// Notes:   answer comes lat_i+1 cycles after the request
`timescale 1ns/100ps
`default_nettype none
module store_model (
  input  wire logic       clk_i,
  input  wire logic       req_i,
  input  wire logic       fail_i,
  input  wire logic [2:0] lat_i,
  output var  logic       done_o,
  output var  logic       bad_o
);
  int cnt = 0;
  initial
  begin
    done_o = 1'b0;
    bad_o = 1'b0;
  end
  // ********************************
  // delayed save answer
  // ********************************
  // a failed store is reported
  always @(posedge clk_i)
  begin
    done_o <= (cnt == 1) && !fail_i;
    bad_o <= (cnt == 1) && fail_i;
    if (req_i)
      cnt <= lat_i + 1;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule // store_model
`default_nettype wire

// ### drive_parameter_command_gate_test.sv
// Purpose: self-checking bench for the command gate
// Assumes: classic Wishbone, ack one cycle after request
// Notes:   expectations tracked in bench variables
`timescale 1ns/100ps
`default_nettype none
module drive_parameter_command_gate_test;
  import gate_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00, acode = 8'h00;
  logic [31:0] wdat = 32'h0, rd, wdo, seed = 32'h6;
  logic drv = 1'b0, act = 1'b0, aset = 1'b0, fail = 1'b0, ack;
  logic [15:0] ofs = 16'h0, refo;
  logic [2:0]  lat = 3'h0;
  logic [3:0]  spd;
  logic sdone, sfail, sinit, calr, mdef, fdef, dprog, psv, sv;
  logic retry, dalm, run, irq;
  int failures = 0, check_count = 0, cycles = 0;
  int pc[8] = '{default: 0};
  drive_parameter_command_gate dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wdo), .wb_ack_o(ack),
    .drive_enabled_i(drv), .alarm_active_i(act), .offset_mv_i(ofs),
    .alarm_set_i(aset), .alarm_code_i(acode), .save_done_i(sdone),
    .save_fail_i(sfail), .serial_init_o(sinit), .serial_speed_o(spd),
    .cal_run_o(calr), .mode_defaults_o(mdef), .full_defaults_o(fdef),
    .default_program_o(dprog), .program_save_o(psv),
    .param_save_o(sv), .display_retry_o(retry),
    .display_alarm_o(dalm), .program_run_o(run),
    .ref_offset_o(refo), .irq_o(irq));
  store_model sm (.clk_i(clk_i), .req_i(psv | sv), .fail_i(fail),
    .lat_i(lat), .done_o(sdone), .bad_o(sfail));
  always #4 clk_i = ~clk_i;
  // ********************************
  // pulse counters and timeout
  // ********************************
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (!rst_i)
    begin
      pc[0] <= pc[0] + sinit;
      pc[1] <= pc[1] + dprog;
      pc[2] <= pc[2] + calr;
      pc[4] <= pc[4] + mdef;
      pc[5] <= pc[5] + fdef;
      pc[6] <= pc[6] + psv;
      pc[7] <= pc[7] + sv;
    end
    if (cycles == 5000)
    begin
      failures++;
      $display("FAIL %0t run timeout", $time);
      end_of_test();
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    rd = wdo;
    cyc <= 1'b0;
    we <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      $display("FAIL %0t bus ack timeout", $time);
    end
  endtask
  // issue one command, check refusal flag and its pulse
  task automatic cmd(input int b, input logic ok);
    int p;
    p = pc[b];
    wb(1'b1, ADR_IRQCLR, 32'hF);
    wb(1'b1, ADR_CMD, 32'h1 << b);
    repeat (3) @(posedge clk_i);
    wb(1'b0, ADR_IRQST, 32'h0);
    chk(rd[EV_REFUSED], !ok);
    chk(pc[b] - p, ok & b inside {0, 4, 5, 6, 7});
  endtask
  task automatic alm(input logic [7:0] c);
    @(posedge clk_i);
    aset <= 1'b1;
    acode <= c;
    @(posedge clk_i);
    aset <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ********************************
  // main sequence
  // ********************************
  initial
  begin
    logic [3:0]  sp;
    logic [15:0] eo;
    logic [15:0] ov[4];
    logic        okn;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(pc[0], 1);
    chk(run, 1'b1);
    wb(1'b1, ADR_IRQEN, 32'hF);
    wb(1'b1, ADR_CTRL, 32'h9);
    wb(1'b1, ADR_REFOFS, 32'h1234);
    wb(1'b0, ADR_REFOFS, 32'h0);
    chk(rd[15:0], 16'h0);
    cmd(CMD_MDEF, 1'b0);
    sp = xs() % 16;
    wb(1'b1, ADR_CTRL, {20'h0, sp, 8'h08});
    cmd(CMD_REINIT, 1'b0);
    wb(1'b1, ADR_CTRL, {20'h0, sp, 8'h0A});
    cmd(CMD_REINIT, 1'b1);
    chk(spd, sp);
    // null only below the offset limit
    ov = '{16'd199, 16'hFF39, 16'd200, 16'(xs() % 199)};
    eo = 16'h0;
    foreach (ov[i])
    begin
      ofs <= ov[i];
      okn = ($signed(ov[i]) < 200) && ($signed(ov[i]) > -200);
      cmd(CMD_NULL, okn);
      if (okn)
        eo = -ov[i];
      chk(refo, eo);
    end
    wb(1'b1, ADR_CTRL, {20'h0, sp, 8'h0E});
    cmd(CMD_MDEF, 1'b0);
    wb(1'b1, ADR_CTRL, {20'h0, sp, 8'h0A});
    cmd(CMD_MDEF, 1'b1);
    alm(8'h05);
    act <= 1'b1;
    // host spaces the alarm reset well after the alarm
    repeat (6) @(posedge clk_i);
    cmd(CMD_ARST, 1'b1);
    wb(1'b0, ADR_ALARM, 32'h0);
    chk(rd[15:0], 16'h0);
    chk(dalm, 1'b1);
    act <= 1'b0;
    // both checksum codes block alarm reset
    alm(ALM_CSUM_A);
    cmd(CMD_ARST, 1'b0);
    alm(ALM_CSUM_B);
    cmd(CMD_ARST, 1'b0);
    cmd(CMD_SAVE, 1'b0);
    cmd(CMD_FDEF, 1'b0);
    wb(1'b0, ADR_ALARM, 32'h0);
    chk(rd[15:0], 16'h0A0B);
    wb(1'b1, ADR_CTRL, {20'h0, sp, 8'h02});
    repeat (2) @(posedge clk_i);
    chk(run, 1'b0);
    cmd(CMD_FDEF, 1'b1);
    chk(pc[1], 1);
    wb(1'b0, ADR_ALARM, 32'h0);
    chk(rd[15:0], 16'h0);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk(rd, 32'h8);
    drv <= 1'b1;
    repeat (8) @(posedge clk_i);
    cmd(CMD_CAL, 1'b0);
    drv <= 1'b0;
    repeat (8) @(posedge clk_i);
    cmd(CMD_CAL, 1'b1);
    chk(pc[2], 0);
    drv <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(pc[2], 1);
    fail <= 1'b1;
    lat <= 3'(xs());
    cmd(CMD_PSAVE, 1'b1);
    repeat (12) @(posedge clk_i);
    chk(retry, 1'b1);
    wb(1'b0, ADR_IRQST, 32'h0);
    chk(rd[EV_RETRY], 1'b1);
    chk(irq, 1'b1);
    wb(1'b1, ADR_IRQEN, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    wb(1'b1, ADR_IRQEN, 32'hF);
    fail <= 1'b0;
    cmd(CMD_SAVE, 1'b1);
    repeat (12) @(posedge clk_i);
    chk(retry, 1'b0);
    wb(1'b0, ADR_IRQST, 32'h0);
    chk(rd[EV_DONE], 1'b1);
    end_of_test();
  end
endmodule // drive_parameter_command_gate_test
`default_nettype wire
